// [common/hsscc_map.vh]
// register map, field positions and timing constants for the switch control block
`ifndef HSSCC_MAP_VH
`define HSSCC_MAP_VH

// ************************************
// register addresses (7-bit)
// ************************************
`define HSSCC_ADDR_TIMER_B    7'h0d
`define HSSCC_ADDR_FAULT_CTRL 7'h10
`define HSSCC_ADDR_SEL_A      7'h14
`define HSSCC_ADDR_SEL_B      7'h15

// ************************************
// field positions and masks
// ************************************
`define HSSCC_ON_HI       6
`define HSSCC_ON_LO       4
`define HSSCC_PER_HI      2
`define HSSCC_PER_LO      0
`define HSSCC_TIMER_MASK  8'h77
`define HSSCC_FAULT_MASK  8'h70
`define HSSCC_SEL_MASK    8'h77
`define HSSCC_OV_DIS_BIT  6
`define HSSCC_UV_DIS_BIT  5
`define HSSCC_REC_BIT     4
`define HSSCC_RESET_VAL   8'h00
`define HSSCC_SW_LO_MSB   2
`define HSSCC_SW_LO_LSB   0
`define HSSCC_SW_HI_MSB   6
`define HSSCC_SW_HI_LSB   4

// ************************************
// selector and on-time codes
// ************************************
`define HSSCC_SRC_OFF     3'h0
`define HSSCC_SRC_ON      3'h1
`define HSSCC_SRC_TMR_A   3'h2
`define HSSCC_SRC_TMR_B   3'h3
`define HSSCC_SRC_PWM_A   3'h4
`define HSSCC_SRC_PWM_B   3'h5
`define HSSCC_ON_STOP_LO  3'h0
`define HSSCC_ON_STOP_HI  3'h6
`define HSSCC_ON_RSVD     3'h7
`define HSSCC_PER_RSVD    3'h7

// ************************************
// timing: one tick per 0.1 ms (100000 ns)
// ************************************
`define HSSCC_CLK_NS      5
`define HSSCC_TICK_NS     100000
`define HSSCC_TICK_CYC    (`HSSCC_TICK_NS / `HSSCC_CLK_NS)
// on-times in ticks
`define HSSCC_ON_T1       16'd1
`define HSSCC_ON_T2       16'd3
`define HSSCC_ON_T3       16'd10
`define HSSCC_ON_T4       16'd100
`define HSSCC_ON_T5       16'd200
// periods in ticks
`define HSSCC_PER_T0      16'd100
`define HSSCC_PER_T1      16'd200
`define HSSCC_PER_T2      16'd500
`define HSSCC_PER_T3      16'd1000
`define HSSCC_PER_T4      16'd2000
`define HSSCC_PER_T5      16'd10000
`define HSSCC_PER_T6      16'd20000

`endif

// [src/hsscc_switch_ctrl.v]
// high-side switch source selection, cyclic timer b and supply fault policy
`include "hsscc_map.vh"

module hsscc_switch_ctrl #(
   parameter TICK_CYC = `HSSCC_TICK_CYC
) (
   input  wire       i_ref_clk,
   input  wire       i_nrst,
   input  wire       i_soft_rst,
   input  wire       i_wr_en,
   input  wire [6:0] i_wr_addr,
   input  wire [7:0] i_wr_data,
   input  wire [6:0] i_rd_addr,
   output reg  [7:0] o_rd_data,
   input  wire       i_restart_mode,
   input  wire       i_cyclic_sense,
   input  wire       i_timer_a_out,
   input  wire       i_pwm_a_out,
   input  wire       i_pwm_b_out,
   input  wire       i_supply_ov,
   input  wire       i_supply_uv,
   input  wire [3:0] i_sw_overcurrent,
   input  wire [3:0] i_sw_overtemp,
   output reg  [3:0] o_switch_on,
   output reg        o_timer_b_out,
   output reg        o_timer_b_on_end
);

   // ************************************
   // input synchronisers (three stages)
   // ************************************
   // a level counts only once stages two and three agree, so one
   // metastable sample cannot trip a shutdown on its own
   wire [9:0] raw = {i_supply_ov, i_supply_uv, i_sw_overcurrent, i_sw_overtemp};
   wire [9:0] flt_s;
   genvar     b;

   generate
      for (b = 0; b < 10; b = b + 1) begin : g_sync
         reg s1_q;
         reg s2_q;
         reg s3_q;
         reg agree_q;
         always @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst) begin
               s1_q    <= 1'h0;
               s2_q    <= 1'h0;
               s3_q    <= 1'h0;
               agree_q <= 1'h0;
            end else begin
               s1_q <= raw[b];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q)
                  agree_q <= s3_q;
            end
         end
         assign flt_s[b] = agree_q;
      end
   endgenerate

   wire       ov_s   = flt_s[9];
   wire       uv_s   = flt_s[8];
   wire [3:0] sw_flt = flt_s[7:4] | flt_s[3:0];

   // ************************************
   // registers
   // ************************************
   reg [7:0] timer_q;
   reg [7:0] fault_q;
   reg [7:0] sel_a_q;
   reg [7:0] sel_b_q;

   wire wr_tmr = i_wr_en && (i_wr_addr == `HSSCC_ADDR_TIMER_B);
   wire wr_flt = i_wr_en && (i_wr_addr == `HSSCC_ADDR_FAULT_CTRL);
   wire wr_sa  = i_wr_en && (i_wr_addr == `HSSCC_ADDR_SEL_A);
   wire wr_sb  = i_wr_en && (i_wr_addr == `HSSCC_ADDR_SEL_B);

   wire sel_cleared = (wr_sa && ((i_wr_data & `HSSCC_SEL_MASK) == 8'h00)) ||
                      (wr_sb && ((i_wr_data & `HSSCC_SEL_MASK) == 8'h00));
   wire tmr_wipe    = sel_cleared && i_restart_mode && i_cyclic_sense;

   // per-switch clear masks for the two selector registers
   wire [7:0] clr_a = {1'b0, {3{sw_flt[1]}}, 1'b0, {3{sw_flt[0]}}};
   wire [7:0] clr_b = {1'b0, {3{sw_flt[3]}}, 1'b0, {3{sw_flt[2]}}};

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         timer_q <= `HSSCC_RESET_VAL;
         fault_q <= `HSSCC_RESET_VAL;
         sel_a_q <= `HSSCC_RESET_VAL;
         sel_b_q <= `HSSCC_RESET_VAL;
      end else if (i_soft_rst) begin
         timer_q <= `HSSCC_RESET_VAL;
         fault_q <= `HSSCC_RESET_VAL;
         sel_a_q <= `HSSCC_RESET_VAL;
         sel_b_q <= `HSSCC_RESET_VAL;
      end else begin
         if (tmr_wipe)
            timer_q <= `HSSCC_RESET_VAL;
         else if (wr_tmr)
            timer_q <= i_wr_data & `HSSCC_TIMER_MASK;
         if (wr_flt)
            fault_q <= i_wr_data & `HSSCC_FAULT_MASK;
         // hardware clear wins over a write
         // the clear repeats while the fault stands, so a write cannot re-arm it
         if (wr_sa)
            sel_a_q <= i_wr_data & `HSSCC_SEL_MASK & ~clr_a;
         else
            sel_a_q <= sel_a_q & ~clr_a;
         if (wr_sb)
            sel_b_q <= i_wr_data & `HSSCC_SEL_MASK & ~clr_b;
         else
            sel_b_q <= sel_b_q & ~clr_b;
      end
   end

   // ************************************
   // register read
   // ************************************
   // read path, reserved bits already zero
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst)
         o_rd_data <= 8'h00;
      else begin
         case (i_rd_addr)
            `HSSCC_ADDR_TIMER_B:    o_rd_data <= timer_q;
            `HSSCC_ADDR_FAULT_CTRL: o_rd_data <= fault_q;
            `HSSCC_ADDR_SEL_A:      o_rd_data <= sel_a_q;
            `HSSCC_ADDR_SEL_B:      o_rd_data <= sel_b_q;
            default:                o_rd_data <= 8'h00;
         endcase
      end
   end

   // ************************************
   // cyclic timer b
   // ************************************
   wire [2:0] on_code  = timer_q[`HSSCC_ON_HI:`HSSCC_ON_LO];
   wire [2:0] per_code = timer_q[`HSSCC_PER_HI:`HSSCC_PER_LO];
   reg  [15:0] on_ticks;
   reg  [15:0] per_ticks;

   always @* begin
      case (on_code)
         3'h1:    on_ticks = `HSSCC_ON_T1;
         3'h2:    on_ticks = `HSSCC_ON_T2;
         3'h3:    on_ticks = `HSSCC_ON_T3;
         3'h4:    on_ticks = `HSSCC_ON_T4;
         3'h5:    on_ticks = `HSSCC_ON_T5;
         default: on_ticks = 16'h0;
      endcase
   end

   always @* begin
      case (per_code)
         3'h0:    per_ticks = `HSSCC_PER_T0;
         3'h1:    per_ticks = `HSSCC_PER_T1;
         3'h2:    per_ticks = `HSSCC_PER_T2;
         3'h3:    per_ticks = `HSSCC_PER_T3;
         3'h4:    per_ticks = `HSSCC_PER_T4;
         3'h5:    per_ticks = `HSSCC_PER_T5;
         3'h6:    per_ticks = `HSSCC_PER_T6;
         default: per_ticks = 16'h0;
      endcase
   end

   // running as soon as a valid on-time and a valid period sit in the register
   // reserved codes leave the timer idle rather than guess a figure
   // an on-time at or beyond the period keeps the output high throughout
   wire run = (on_ticks != 16'h0) && (per_ticks != 16'h0);
   wire tick;
   reg  [15:0] ph_q;
   reg         run_q;

   hsscc_tick_div #(
      .DIV (TICK_CYC)
   ) u_div (
      .i_ref_clk (i_ref_clk),
      .i_nrst    (i_nrst),
      .i_clr     (~run | wr_tmr),
      .o_tick    (tick)
   );

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ph_q             <= 16'h0;
         run_q            <= 1'b0;
         o_timer_b_out    <= 1'b0;
         o_timer_b_on_end <= 1'b0;
      end else begin
         // a write restarts the period, so the next cycle must look like a fresh start
         run_q            <= run && !wr_tmr;
         o_timer_b_on_end <= 1'b0;
         if (!run || wr_tmr) begin
            ph_q <= 16'h0;
            // stop low; stop high on code six
            o_timer_b_out <= (on_code == `HSSCC_ON_STOP_HI);
            // a write to a running timer drops the output for one cycle; the fresh start then opens the period high
            if (run)
               o_timer_b_out <= 1'b0;
         end else if (!run_q) begin
            o_timer_b_out <= 1'b1;
         end else if (tick) begin
            if (ph_q + 16'h1 >= per_ticks) begin
               ph_q          <= 16'h0;
               o_timer_b_out <= 1'b1;
            end else begin
               ph_q <= ph_q + 16'h1;
               if (ph_q + 16'h1 == on_ticks) begin
                  o_timer_b_out    <= 1'b0;
                  o_timer_b_on_end <= 1'b1;
               end
            end
         end
      end
   end

   // ************************************
   // supply fault policy
   // ************************************
   // overvoltage trip unless disabled
   wire ov_trip   = ov_s && !fault_q[`HSSCC_OV_DIS_BIT];
   wire uv_trip   = uv_s && !fault_q[`HSSCC_UV_DIS_BIT];
   wire sup_fault = ov_trip || uv_trip;
   reg  latched_off_q;

   // two 3-bit selector fields per register
   wire [2:0]  sel_one   = sel_a_q[`HSSCC_SW_LO_MSB:`HSSCC_SW_LO_LSB];
   wire [2:0]  sel_two   = sel_a_q[`HSSCC_SW_HI_MSB:`HSSCC_SW_HI_LSB];
   wire [2:0]  sel_three = sel_b_q[`HSSCC_SW_LO_MSB:`HSSCC_SW_LO_LSB];
   wire [2:0]  sel_four  = sel_b_q[`HSSCC_SW_HI_MSB:`HSSCC_SW_HI_LSB];
   wire [11:0] sel_all   = {sel_four, sel_three, sel_two, sel_one};

   // recovery versus latched off; a new selector write releases the latch unless a supply trip stands in that cycle
   // with recovery off only a selector write or soft reset lets switches on again
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst)
         latched_off_q <= 1'b0;
      else if (i_soft_rst || wr_sa || wr_sb)
         latched_off_q <= sup_fault;
      else if (sup_fault && !fault_q[`HSSCC_REC_BIT])
         latched_off_q <= 1'b1;
   end

   wire block_sw = sup_fault || latched_off_q;

   // ************************************
   // switch drive
   // ************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_sw
         wire [2:0] sel = sel_all[3*g+2:3*g];
         reg        src;
         always @* begin
            case (sel)
               `HSSCC_SRC_ON:    src = 1'b1;
               `HSSCC_SRC_TMR_A: src = i_timer_a_out;
               `HSSCC_SRC_TMR_B: src = o_timer_b_out;
               `HSSCC_SRC_PWM_A: src = i_pwm_a_out;
               `HSSCC_SRC_PWM_B: src = i_pwm_b_out;
               default:          src = 1'b0;
            endcase
         end
         always @(posedge i_ref_clk or negedge i_nrst) begin
            if (!i_nrst)
               o_switch_on[g] <= 1'b0;
            else
               o_switch_on[g] <= src && !block_sw && !sw_flt[g];
         end
      end
   endgenerate

endmodule // hsscc_switch_ctrl

// [src/hsscc_tick_div.v]
// tick divider producing a one-cycle enable pulse
module hsscc_tick_div #(
   parameter DIV = 20000
) (
   input  wire i_ref_clk,
   input  wire i_nrst,
   input  wire i_clr,
   output reg  o_tick
);
   reg [31:0] cnt_q;

   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt_q  <= 32'h0;
         o_tick <= 1'b0;
      end else if (i_clr) begin
         cnt_q  <= 32'h0;
         o_tick <= 1'b0;
      end else if (cnt_q == DIV - 1) begin
         cnt_q  <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         cnt_q  <= cnt_q + 32'h1;
         o_tick <= 1'b0;
      end
   end
endmodule // hsscc_tick_div

// [test/hsscc_host_model.sv]
// host model driving the register write and read ports
module hsscc_host_model (
   input  wire       i_ref_clk,
   input  wire [7:0] i_rd_data,
   output reg        o_wr_en,
   output reg  [6:0] o_wr_addr,
   output reg  [7:0] o_wr_data,
   output reg  [6:0] o_rd_addr
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      o_wr_en = 1'b0; o_wr_addr = 7'h00; o_wr_data = 8'h00; o_rd_addr = 7'h7f;
   end
   // stale data inverted after the strobe, no kinder than a real host
   task wr(input logic [6:0] a, input logic [7:0] v);
      @(negedge i_ref_clk);
      o_wr_en = 1'b1; o_wr_addr = a; o_wr_data = v;
      @(negedge i_ref_clk);
      o_wr_en = 1'b0; o_wr_data = ~v;
   endtask
   task rd(input logic [6:0] a, output logic [7:0] v);
      @(negedge i_ref_clk);
      o_rd_addr = a;
      @(negedge i_ref_clk);
      v = i_rd_data;
   endtask
endmodule // hsscc_host_model

// [test/hsscc_monitor.sv]
// assertion checker for the switch control block
`include "hsscc_map.vh"
module hsscc_monitor #(
   parameter TICK_CYC = 4
) (
   input wire       i_ref_clk,
   input wire       i_nrst,
   input wire       i_soft_rst,
   input wire       i_wr_en,
   input wire [6:0] i_wr_addr,
   input wire [7:0] i_wr_data,
   input wire [6:0] i_rd_addr,
   input wire [7:0] o_rd_data,
   input wire       i_supply_ov,
   input wire       i_supply_uv,
   input wire [3:0] i_sw_overcurrent,
   input wire [3:0] i_sw_overtemp,
   input wire [3:0] o_switch_on,
   input wire       o_timer_b_out,
   input wire       o_timer_b_on_end
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_nrst);
   // ***
   // shadow of fault policy bits
   // ***
   reg [7:0] flt_q;
   always @(posedge i_ref_clk or negedge i_nrst) begin
      if (!i_nrst) flt_q <= 8'h00;
      else if (i_soft_rst) flt_q <= 8'h00;
      else if (i_wr_en && i_wr_addr == `HSSCC_ADDR_FAULT_CTRL) flt_q <= i_wr_data;
   end
   // 8 cycles covers the input sync latency
   property p_flt_rsvd; i_rd_addr == `HSSCC_ADDR_FAULT_CTRL |=> (o_rd_data & 8'h8f) == 8'h00; endproperty
   a_flt_rsvd: assert property (p_flt_rsvd) else $error("fault reg reserved bits set");
   property p_sel_rsvd; i_rd_addr inside {`HSSCC_ADDR_TIMER_B, `HSSCC_ADDR_SEL_A, `HSSCC_ADDR_SEL_B}
      |=> !o_rd_data[7] && !o_rd_data[3]; endproperty
   a_sel_rsvd: assert property (p_sel_rsvd) else $error("reserved bit read as one");
   property p_unmap; !(i_rd_addr inside {`HSSCC_ADDR_TIMER_B, `HSSCC_ADDR_FAULT_CTRL, `HSSCC_ADDR_SEL_A,
      `HSSCC_ADDR_SEL_B}) |=> o_rd_data == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_oc; i_sw_overcurrent[0] [*8] |-> !o_switch_on[0]; endproperty
   a_oc: assert property (p_oc) else $error("switch on during overcurrent");
   property p_ot; i_sw_overtemp[1] [*8] |-> !o_switch_on[1]; endproperty
   a_ot: assert property (p_ot) else $error("switch on during overtemperature");
   property p_ov; (i_supply_ov && !flt_q[6]) [*8] |-> o_switch_on == 4'h0; endproperty
   a_ov: assert property (p_ov) else $error("no overvoltage shutdown");
   property p_uv; (i_supply_uv && !flt_q[5]) [*8] |-> o_switch_on == 4'h0; endproperty
   a_uv: assert property (p_uv) else $error("no undervoltage shutdown");
   property p_end; o_timer_b_on_end |-> $past(o_timer_b_out) && !o_timer_b_out ##1 !o_timer_b_on_end; endproperty
   a_end: assert property (p_end) else $error("on-time end pulse misplaced");
   c_end: cover property (o_timer_b_on_end);
   c_ov: cover property (i_supply_ov && !flt_q[6] ##8 o_switch_on == 4'h0);
   c_oc: cover property (i_sw_overcurrent[0] ##8 !o_switch_on[0]);
endmodule // hsscc_monitor
bind hsscc_switch_ctrl hsscc_monitor #(.TICK_CYC(TICK_CYC)) i_hsscc_monitor (
   .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_soft_rst(i_soft_rst), .i_wr_en(i_wr_en),
   .i_wr_addr(i_wr_addr), .i_wr_data(i_wr_data), .i_rd_addr(i_rd_addr), .o_rd_data(o_rd_data),
   .i_supply_ov(i_supply_ov), .i_supply_uv(i_supply_uv), .i_sw_overcurrent(i_sw_overcurrent),
   .i_sw_overtemp(i_sw_overtemp), .o_switch_on(o_switch_on), .o_timer_b_out(o_timer_b_out),
   .o_timer_b_on_end(o_timer_b_on_end));

// [test/hsscc_switch_ctrl_tb_top.sv]
// self-checking bench for the switch control block
module hsscc_switch_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam TK = 4;
   logic       clk, nrst, srst, rmode, csense, tma, pwa, pwb, ov, uv;
   logic [3:0] oc, ot;
   logic [7:0] d;
   logic       seen_end;
   wire        wr_en, tb_out, tb_end;
   wire  [6:0] wr_addr, rd_addr;
   wire  [7:0] wr_data, rd_data;
   wire  [3:0] sw_on;
   int         num_errors, total_checks, cyc, hi, per;
   // rows: address, value written, value read back
   logic [6:0] ra [5] = '{7'h0d, 7'h10, 7'h14, 7'h15, 7'h11};
   logic [7:0] rw [5] = '{8'hee, 8'hff, 8'hdd, 8'hcb, 8'hff};
   logic [7:0] rx [5] = '{8'h66, 8'h70, 8'h55, 8'h43, 8'h00};
   int         on_t [6] = '{0, 1, 3, 10, 100, 200};
   int         per_t [5] = '{100, 200, 500, 1000, 2000};
   hsscc_switch_ctrl #(.TICK_CYC(TK)) i_hsscc_switch_ctrl (.i_ref_clk(clk), .i_nrst(nrst),
      .i_soft_rst(srst), .i_wr_en(wr_en), .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
      .o_rd_data(rd_data), .i_restart_mode(rmode), .i_cyclic_sense(csense), .i_timer_a_out(tma),
      .i_pwm_a_out(pwa), .i_pwm_b_out(pwb), .i_supply_ov(ov), .i_supply_uv(uv), .i_sw_overcurrent(oc),
      .i_sw_overtemp(ot), .o_switch_on(sw_on), .o_timer_b_out(tb_out), .o_timer_b_on_end(tb_end));
   hsscc_host_model h (.i_ref_clk(clk), .i_rd_data(rd_data), .o_wr_en(wr_en), .o_wr_addr(wr_addr),
      .o_wr_data(wr_data), .o_rd_addr(rd_addr));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task w10;
      repeat (10) @(negedge clk);
   endtask
   // high time and period of timer b output in cycles, bounded waits
   task meas;
      hi = 0; per = 0;
      while (tb_out !== 1'b0 && per < 9000) begin @(negedge clk); per++; end
      while (tb_out !== 1'b1 && per < 18000) begin @(negedge clk); per++; end
      per = 0;
      while (tb_out === 1'b1 && per < 9000) begin @(negedge clk); hi++; per++; end
      seen_end = tb_end;
      while (tb_out !== 1'b1 && per < 9000) begin @(negedge clk); per++; end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 90000) begin num_errors++; wrap_up; end
   end
   initial begin
      {nrst, srst, rmode, csense, tma, pwa, pwb, ov, uv, oc, ot} = '0;
      repeat (12) @(negedge clk);
      nrst = 1'b1;
      // table rows; host never writes on-time code seven
      for (int i = 0; i < 5; i++) begin
         h.wr(ra[i], rw[i]);
         h.rd(ra[i], d);
         chk("reg", d, rx[i]);
      end
      $display("test rows done");
      for (int k = 0; k < 2; k++) begin
         for (int i = 0; i < 4; i++) h.wr(ra[i], rw[i]);
         @(negedge clk);
         if (k == 0) srst = 1'b1; else nrst = 1'b0;
         @(negedge clk);
         srst = 1'b0; nrst = 1'b1;
         for (int i = 0; i < 4; i++) begin h.rd(ra[i], d); chk("reset", d, 8'h00); end
      end
      $display("test reset done");
      h.wr(7'h14, 8'h03);
      for (int i = 1; i < 6; i++) begin
         h.wr(7'h0d, {1'b0, i[2:0], 4'h2});
         meas;
         chk("on", hi, on_t[i] * TK);
         chk("per", per, per_t[2] * TK);
         chk("on end", seen_end, 1'b1);
      end
      for (int p = 0; p < 5; p++) begin
         h.wr(7'h0d, {5'h02, p[2:0]});
         @(negedge clk);
         chk("restart", tb_out, 1'b1);
         meas;
         chk("per", per, per_t[p] * TK);
      end
      h.wr(7'h0d, 8'h60);
      w10;
      chk("stop hi", {tb_out, sw_on[0]}, 2'b11);
      h.wr(7'h0d, 8'h00);
      w10;
      chk("stop lo", {tb_out, sw_on[0]}, 2'b00);
      $display("test timer done");
      h.wr(7'h14, 8'h11); h.wr(7'h10, 8'h10);
      ov = 1'b1; w10; chk("ov", sw_on, 4'h0);
      ov = 1'b0; w10; chk("rec", sw_on, 4'h3);
      h.wr(7'h10, 8'h40);
      ov = 1'b1; w10; chk("ov dis", sw_on, 4'h3);
      ov = 1'b0; w10; h.wr(7'h10, 8'h00);
      uv = 1'b1; w10; chk("uv", sw_on, 4'h0);
      uv = 1'b0; w10; chk("no rec", sw_on, 4'h0);
      h.wr(7'h10, 8'h20); h.wr(7'h14, 8'h11);
      uv = 1'b1; w10; chk("uv dis", sw_on, 4'h3);
      uv = 1'b0; oc = 4'h1; w10;
      chk("oc", sw_on, 4'h2);
      h.rd(7'h14, d); chk("oc sel", d, 8'h10);
      oc = 4'h0; ot = 4'h2; w10;
      chk("ot", sw_on, 4'h0);
      h.rd(7'h14, d); chk("ot sel", d, 8'h00);
      ot = 4'h0;
      $display("test faults done");
      rmode = 1'b1; csense = 1'b1;
      h.wr(7'h0d, 8'h12); h.wr(7'h15, 8'h00); h.wr(7'h14, 8'h00);
      h.rd(7'h0d, d); chk("wipe", d, 8'h00);
      rmode = 1'b0; csense = 1'b0;
      h.wr(7'h14, 8'h42); h.wr(7'h15, 8'h05);
      for (int v = 0; v < 8; v++) begin
         {pwb, pwa, tma} = v[2:0];
         repeat (3) @(negedge clk);
         chk("route", sw_on, {1'b0, v[2:0]});
      end
      $display("test routing done");
      wrap_up;
   end
endmodule // hsscc_switch_ctrl_tb_top
